// file: core/pa_phase_accum.sv
// Register side and accumulator of the numerically controlled oscillator.
// Functional notes
// - Accumulator spans three bytes, 20 bits implemented.
// - Top byte holds bits 19:16, upper nibble zero.
// - Accumulator runs free, no atomic multi-byte access.
// - Increment from upper, high, low bytes.
// - Shadow loads on falling edge after low write.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "pa_consts.svh"
module pa_phase_accum #(
  parameter int ACC_W = `PA_ACC_W
) (
  // Clock and reset.
  input  wire logic                i_mclk,
  input  wire logic                i_rst_b,
  // Register bus.
  input  wire pa_pkg::pa_bus_req_s i_bus,
  output logic [7:0]               o_rdata,
  // Oscillator source clock pin.
  input  wire logic                i_osc_src_clk,
  // Status out.
  output logic [ACC_W-1:0]         o_phase,
  output logic                     o_overflow
);
  import pa_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [23:0]      inc_q;
  logic [23:0]      shadow_q;
  logic             pend_q;
  logic             en_q;
  logic [7:0]       rdata_q;
  logic             ovf_q;
  logic             src_rise;
  logic             src_fall;

  // Source clock crosses through two flops before any edge is seen.
  pa_edge_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_async (i_osc_src_clk),
    .o_rise  (src_rise),
    .o_fall  (src_fall)
  );

  // ****************************************
  // Decode
  // ****************************************
  wire wr_acc_l  = i_bus.wr && (i_bus.addr == `PA_OFF_ACC_LOW);
  wire wr_acc_h  = i_bus.wr && (i_bus.addr == `PA_OFF_ACC_HIGH);
  wire wr_acc_u  = i_bus.wr && (i_bus.addr == `PA_OFF_ACC_TOP);
  wire wr_inc_l  = i_bus.wr && (i_bus.addr == `PA_OFF_INC_LOW);
  wire wr_inc_h  = i_bus.wr && (i_bus.addr == `PA_OFF_INC_HIGH);
  wire wr_inc_u  = i_bus.wr && (i_bus.addr == `PA_OFF_INC_UPPER);
  wire wr_ctrl   = i_bus.wr && (i_bus.addr == `PA_OFF_CTRL);
  wire step      = en_q && src_rise;
  wire [ACC_W:0] sum = {1'b0, acc_q} + {1'b0, shadow_q[ACC_W-1:0]};

  // The accumulator steps on its own; a byte write in the same cycle wins for that byte only, and a
  // byte write mixed with stepping gives unpredictable totals, as software is warned.
  always_comb begin
    acc_d = acc_q;
    if (step) begin
      acc_d = sum[ACC_W-1:0];
    end
    if (wr_acc_l) begin
      acc_d[7:0] = i_bus.wdata;
    end
    if (wr_acc_h) begin
      acc_d[15:8] = i_bus.wdata;
    end
    if (wr_acc_u) begin
      acc_d[ACC_W-1:16] = i_bus.wdata[`PA_TOP_NIB_W-1:0];
    end
  end

  // Read mux; unmapped offsets read zero.
  wire [7:0] rd_mux =
    (i_bus.addr == `PA_OFF_ACC_LOW)   ? acc_q[7:0] :
    (i_bus.addr == `PA_OFF_ACC_HIGH)  ? acc_q[15:8] :
    (i_bus.addr == `PA_OFF_ACC_TOP)   ? {4'h0, acc_q[ACC_W-1:16]} :
    (i_bus.addr == `PA_OFF_INC_LOW)   ? inc_q[7:0] :
    (i_bus.addr == `PA_OFF_INC_HIGH)  ? inc_q[15:8] :
    (i_bus.addr == `PA_OFF_INC_UPPER) ? inc_q[23:16] :
    (i_bus.addr == `PA_OFF_CTRL)      ? {6'h00, pend_q, en_q} : 8'h00;

  // ****************************************
  // Registers
  // ****************************************
  // Accumulator and bus-written registers.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_q   <= `PA_RST_ACC;
      ovf_q   <= 1'b0;
      en_q    <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      acc_q   <= acc_d;
      ovf_q   <= step && sum[ACC_W];
      rdata_q <= i_bus.rd ? rd_mux : 8'h00;
      if (wr_ctrl) begin
        en_q <= i_bus.wdata[`PA_CTRL_EN_BIT];
      end
    end
  end

  // Increment bytes; only a low-byte write arms the shadow load.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      inc_q <= `PA_RST_INC;
    end else begin
      if (wr_inc_l) inc_q[7:0] <= i_bus.wdata;
      if (wr_inc_h) inc_q[15:8] <= i_bus.wdata;
      if (wr_inc_u) inc_q[23:16] <= i_bus.wdata;
    end
  end

  // Shadow loads from the whole increment at the next falling source edge after
  // a low-byte write; a new low write in the falling-edge cycle keeps it pending.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shadow_q <= `PA_RST_INC;
      pend_q   <= 1'b0;
    end else begin
      if (pend_q && src_fall) begin
        shadow_q <= inc_q;
      end
      pend_q <= wr_inc_l || (pend_q && !src_fall);
    end
  end

  assign o_rdata    = rdata_q;
  assign o_phase    = acc_q;
  assign o_overflow = ovf_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_top_nibble_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $past(i_bus.rd) && ($past(i_bus.addr) == `PA_OFF_ACC_TOP) |-> o_rdata[7:4] == 4'h0)
    else $error("Top accumulator byte upper nibble not zero.");
  a_shadow_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pend_q && src_fall |=> shadow_q == $past(inc_q))
    else $error("Shadow did not load on falling edge.");
  a_shadow_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !(pend_q && src_fall) |=> $stable(shadow_q))
    else $error("Shadow changed without a pending load.");
  a_low_arms: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_inc_l |=> pend_q)
    else $error("Low increment write did not arm load.");
  a_acc_step: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    step && !i_bus.wr |=> acc_q == $past(acc_q) + $past(shadow_q[ACC_W-1:0]))
    else $error("Accumulator did not add increment.");
  a_acc_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !step && !i_bus.wr |=> $stable(acc_q))
    else $error("Accumulator moved without a step.");
  a_inc_low_rd: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_inc_l ##1 !i_bus.wr ##1 (i_bus.rd && i_bus.addr == `PA_OFF_INC_LOW && !i_bus.wr)
    |=> o_rdata == $past(i_bus.wdata, 3))
    else $error("Low increment byte read back wrong.");
  a_acc_high_wr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_acc_h |=> acc_q[15:8] == $past(i_bus.wdata))
    else $error("Accumulator high byte write lost.");
  c_shadow_load: cover property (@(posedge i_mclk) disable iff (!i_rst_b) pend_q && src_fall);
  c_wrap: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_overflow);
  c_top_read: cover property (@(posedge i_mclk) disable iff (!i_rst_b) i_bus.rd && i_bus.addr == `PA_OFF_ACC_TOP);
endmodule

// file: core/pa_consts.svh
// Register offsets, field positions, reset values and widths of the phase accumulator block.
`ifndef PA_CONSTS_SVH
`define PA_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define PA_OFF_ACC_LOW   4'h0
`define PA_OFF_ACC_HIGH  4'h1
`define PA_OFF_ACC_TOP   4'h2
`define PA_OFF_INC_LOW   4'h3
`define PA_OFF_INC_HIGH  4'h4
`define PA_OFF_INC_UPPER 4'h5
`define PA_OFF_CTRL      4'h6
// ****************************************
// Fields and reset values
// ****************************************
`define PA_ACC_W         20
`define PA_TOP_NIB_W     4
`define PA_CTRL_EN_BIT   0
`define PA_CTRL_PEND_BIT 1
`define PA_RST_ACC       20'h00000
`define PA_RST_INC       24'h000001
`endif

// file: core/pa_pkg.sv
// Types shared by the phase accumulator files.
package pa_pkg;
  // Register bus request from software.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pa_bus_req_s;
  // Edge-detector state of the synchronised source clock.
  typedef enum logic [1:0] {
    PA_CLK_LOW  = 2'b00,
    PA_CLK_HIGH = 2'b01
  } pa_clk_lvl_e;
endpackage

// file: core/pa_edge_sync.sv
// Two-flop synchroniser and edge detector for the oscillator source clock.
`timescale 1ns/1ps
module pa_edge_sync (
  // Clock and reset.
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  // Asynchronous source level.
  input  wire logic i_async,
  // Edge pulses in the i_mclk domain.
  output logic      o_rise,
  output logic      o_fall
);
  import pa_pkg::*;

  logic        meta_q;
  logic        sync_q;
  pa_clk_lvl_e lvl_q;

  // Only sync_q reads meta_q; the edge logic looks at sync_q and lvl_q.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      lvl_q  <= PA_CLK_LOW;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      lvl_q  <= sync_q ? PA_CLK_HIGH : PA_CLK_LOW;
    end
  end

  // Pulses last one cycle each.
  assign o_rise = sync_q && (lvl_q == PA_CLK_LOW);
  assign o_fall = !sync_q && (lvl_q == PA_CLK_HIGH);
endmodule

// file: testbench/phase_accumulator_regs_tb.sv
// Self-checking testbench of the phase accumulator register block.
`timescale 1ns/1ps
`include "pa_consts.svh"
module phase_accumulator_regs_tb;
  import pa_pkg::*;
  // ****************************************
  // Signals and comparison
  // ****************************************
  `define PA_CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
  logic        i_mclk     = 1'b0;
  logic        i_rst_b    = 1'b0;
  pa_bus_req_s bus        = '0;
  logic        src        = 1'b0;
  logic [7:0]  o_rdata;
  logic [19:0] o_phase;
  logic        o_overflow;
  int          n_errors   = 0;
  int          n_tests    = 0;
  int          n_ovf      = 0;
  // Clock at 40 MHz, and a tally of wrap pulses.
  always #12.5 i_mclk = ~i_mclk;
  // Sampled mid-cycle so that each one-cycle pulse is seen once and settled.
  always @(negedge i_mclk) if (o_overflow === 1'b1) n_ovf++;
  // Expected running total: start value plus steps times the used increment bits.
  function automatic longint exp_total(input logic [19:0] s0, input int steps, input logic [23:0] i0);
    return longint'(s0) + longint'(steps) * longint'(i0[19:0]);
  endfunction
  pa_phase_accum #(.ACC_W(20)) u_dut (
    .i_mclk        (i_mclk),
    .i_rst_b       (i_rst_b),
    .i_bus         (bus),
    .o_rdata       (o_rdata),
    .i_osc_src_clk (src),
    .o_phase       (o_phase),
    .o_overflow    (o_overflow)
  );
  // ****************************************
  // Bus and source clock tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1;
    `PA_CHK(o_rdata, e)
  endtask
  // Source period of eight cycles keeps it well below a quarter of the bus clock.
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_mclk);
      src <= 1'b1;
      repeat (4) @(posedge i_mclk);
      src <= 1'b0;
    end
    repeat (8) @(posedge i_mclk);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [19:0] s;
    logic [23:0] inc;
    int          n;
    longint      sum;
    int          seed;
    seed = $urandom(32'h7CD2);
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    chk_rd(`PA_OFF_ACC_LOW, 8'h00);
    chk_rd(`PA_OFF_ACC_TOP, 8'h00);
    chk_rd(`PA_OFF_INC_LOW, 8'h01);
    chk_rd(`PA_OFF_INC_UPPER, 8'h00);
    wr(4'hF, 8'hFF);
    chk_rd(4'hF, 8'h00);
    // First two passes are corners: full-scale wrap and the smallest step.
    for (int k = 0; k < 6; k++) begin
      s = (k == 0) ? 20'hFFFFF : 20'($urandom);
      inc = (k == 0) ? 24'hFFFFFF : ((k == 1) ? 24'h000001 : 24'($urandom));
      n = (k < 2) ? 3 : 1 + ($urandom % 20);
      wr(`PA_OFF_ACC_LOW, s[7:0]);
      wr(`PA_OFF_ACC_HIGH, s[15:8]);
      wr(`PA_OFF_ACC_TOP, {4'hF, s[19:16]});
      chk_rd(`PA_OFF_ACC_HIGH, s[15:8]);
      chk_rd(`PA_OFF_ACC_TOP, {4'h0, s[19:16]});
      wr(`PA_OFF_INC_UPPER, inc[23:16]);
      wr(`PA_OFF_INC_HIGH, inc[15:8]);
      wr(`PA_OFF_INC_LOW, inc[7:0]);
      chk_rd(`PA_OFF_INC_LOW, inc[7:0]);
      chk_rd(`PA_OFF_CTRL, 8'h02);
      pulse(1);
      chk_rd(`PA_OFF_CTRL, 8'h00);
      chk_rd(`PA_OFF_INC_UPPER, inc[23:16]);
      `PA_CHK(o_phase, s)
      n_ovf = 0;
      wr(`PA_OFF_CTRL, 8'h01);
      chk_rd(`PA_OFF_CTRL, 8'h01);
      pulse(n);
      wr(`PA_OFF_CTRL, 8'h00);
      #1;
      sum = exp_total(s, n, inc);
      `PA_CHK(o_phase, sum[19:0])
      `PA_CHK(n_ovf, int'(sum >>> 20))
      chk_rd(`PA_OFF_ACC_LOW, sum[7:0]);
    end
    summarize();
  end
  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    $display("Error %0t: run did not finish", $time);
    summarize();
  end
endmodule
